// ==== design/debug_id_pkg.sv ====
/*
  Constants shared by the debug identification and status block.
  Assumes a single 100 MHz clock and an active-low asynchronous reset.
*/
package debug_id_pkg;

  // Identification word field positions
  localparam int unsigned WATCH_MSB    = 31;
  localparam int unsigned WATCH_LSB    = 28;
  localparam int unsigned BREAK_MSB    = 27;
  localparam int unsigned BREAK_LSB    = 24;
  localparam int unsigned CTXID_MSB    = 23;
  localparam int unsigned CTXID_LSB    = 20;
  localparam int unsigned VERSION_MSB  = 19;
  localparam int unsigned VERSION_LSB  = 16;
  localparam int unsigned DEVID_BIT    = 15;
  localparam int unsigned NO_SUH_BIT   = 14;
  localparam int unsigned PCSAMPLE_BIT = 13;
  localparam int unsigned SECEXT_BIT   = 12;
  localparam int unsigned RSVD_MSB     = 11;
  localparam int unsigned RSVD_LSB     = 8;
  localparam int unsigned VARIANT_MSB  = 7;
  localparam int unsigned VARIANT_LSB  = 4;
  localparam int unsigned REVISION_MSB = 3;
  localparam int unsigned REVISION_LSB = 0;

  // Identification word constant field values
  localparam logic [3:0] WATCHPOINT_PAIR_CODE = 4'h1;
  localparam logic [3:0] BREAKPOINT_PAIR_CODE = 4'h2;
  localparam logic [3:0] CONTEXT_PAIR_CODE    = 4'h0;
  localparam logic [3:0] RESERVED_ID_CODE     = 4'h0;
  localparam logic       DEVICE_ID_PRESENT    = 1'b1;
  localparam logic       SECURE_USER_HALT_NO  = 1'b1;
  localparam logic       PC_SAMPLE_PRESENT    = 1'b1;
  localparam logic       SECURITY_EXT_PRESENT = 1'b1;

  // Main identification register source fields
  localparam int unsigned MAIN_VARIANT_MSB  = 23;
  localparam int unsigned MAIN_VARIANT_LSB  = 20;
  localparam int unsigned MAIN_REVISION_MSB = 3;
  localparam int unsigned MAIN_REVISION_LSB = 0;

  // Status and control word field positions
  localparam int unsigned STAT_RSVD_HI_BIT = 31;
  localparam int unsigned STAT_RECEIVE_FULL_FLAG_BIT  = 30;
  localparam int unsigned STAT_TRANSMIT_FULL_FLAG_BIT  = 29;
  localparam int unsigned STAT_RSVD_LO_BIT = 28;
  localparam int unsigned STAT_UDIS_BIT    = 12;

  // Reset values
  localparam logic        FULL_RESET = 1'b0;
  localparam logic        UDIS_RESET = 1'b0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Debugger-side register numbers
  localparam logic [9:0] EXT_NUM_IDENT  = 10'h000;
  localparam logic [9:0] EXT_NUM_RX     = 10'h020;
  localparam logic [9:0] EXT_NUM_STATUS = 10'h022;
  localparam logic [9:0] EXT_NUM_TX     = 10'h023;

  // Coprocessor encodings {opc1, crn, crm, opc2}
  localparam logic [2:0] CP_OPC1_BASE   = 3'h0;
  localparam logic [3:0] CP_CRN_BASE    = 4'h0;
  localparam logic [3:0] CP_CRM_IDENT   = 4'h0;
  localparam logic [3:0] CP_CRM_STATUS  = 4'h1;
  localparam logic [3:0] CP_CRM_TRANS   = 4'h5;
  localparam logic [2:0] CP_OPC2_BASE   = 3'h0;

  // Response buffer shape
  localparam int unsigned RESP_DEPTH = 2;

endpackage

// ==== design/debug_id_status.sv ====
/*
  Debug identification word and the channel flags of the status word,
  seen by the processor through coprocessor accesses and by the
  debugger through numbered register accesses.
  Assumes all inputs synchronous to ref_clk_i and the processor reset.
*/
//
// Operation
// - Top nibble reports two watchpoint pairs
// - Bits 27:24 report three breakpoint pairs
// - Bits 23:20 read zero, one context pair
// - Bits 19:16 hold fixed architecture version
// - Bit 15 set: device identification present
// - Bit 14 set: secure user halting unsupported
// - Bit 13 set: pc sample register exists
// - Bit 12 set: security extensions present
// - Bits 7:4 mirror main variant field
// - Bits 3:0 mirror main revision field
// - Identification read at all-zero coprocessor encoding
// - User access refused when disable bit set
// - Status bits 31, 28 read zero
// - Status bit 30 shows receive full, resets zero
// - Debugger write sets receive full
// - Processor read clears receive full
// - Status bit 29 shows transmit full, resets zero
// - Debugger read clears transmit full
// - Processor write sets transmit full
`timescale 1ns/100ps
module debug_id_status #(
  parameter logic [3:0]  ARCH_VERSION = 4'h5, // Arbitrary value
  parameter int unsigned DATA_WIDTH   = 32
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [31:0]           main_id_i,
  input  wire logic                  cp_valid_i,
  output logic                       cp_ready_o,
  input  wire logic                  cp_write_i,
  input  wire logic                  cp_user_i,
  input  wire logic [2:0]            cp_opc1_i,
  input  wire logic [3:0]            cp_crn_i,
  input  wire logic [3:0]            cp_crm_i,
  input  wire logic [2:0]            cp_opc2_i,
  input  wire logic [DATA_WIDTH-1:0] cp_wdata_i,
  output logic                       cp_rsp_valid_o,
  input  wire logic                  cp_rsp_ready_i,
  output logic [DATA_WIDTH-1:0]      cp_rsp_rdata_o,
  output logic                       cp_rsp_undef_o,
  input  wire logic                  ext_valid_i,
  input  wire logic                  ext_write_i,
  input  wire logic [9:0]            ext_num_i,
  input  wire logic [DATA_WIDTH-1:0] ext_wdata_i,
  output logic                       ext_rvalid_o,
  output logic [DATA_WIDTH-1:0]      ext_rdata_o,
  output logic                       rx_full_o,
  output logic                       tx_full_o
);

  logic [DATA_WIDTH-1:0] ident_word;
  logic [DATA_WIDTH-1:0] status_word;
  logic [DATA_WIDTH-1:0] rx_data;
  logic [DATA_WIDTH-1:0] tx_data;
  logic                  rx_full;
  logic                  tx_full;
  logic                  user_disable;
  logic                  cp_take;
  logic                  cp_base;
  logic                  cp_is_ident;
  logic                  cp_is_status;
  logic                  cp_is_trans;
  logic                  cp_refused;
  logic                  cp_undef;
  logic [DATA_WIDTH-1:0] cp_rdata;
  logic                  rx_fill;
  logic                  rx_drain;
  logic                  tx_fill;
  logic                  tx_drain;

  // Identification word
  always_comb begin
    ident_word = '0;
    ident_word[debug_id_pkg::WATCH_MSB:debug_id_pkg::WATCH_LSB] =
      debug_id_pkg::WATCHPOINT_PAIR_CODE;
    ident_word[debug_id_pkg::BREAK_MSB:debug_id_pkg::BREAK_LSB] =
      debug_id_pkg::BREAKPOINT_PAIR_CODE;
    ident_word[debug_id_pkg::CTXID_MSB:debug_id_pkg::CTXID_LSB] =
      debug_id_pkg::CONTEXT_PAIR_CODE;
    ident_word[debug_id_pkg::VERSION_MSB:debug_id_pkg::VERSION_LSB] = ARCH_VERSION;
    ident_word[debug_id_pkg::DEVID_BIT]    = debug_id_pkg::DEVICE_ID_PRESENT;
    ident_word[debug_id_pkg::NO_SUH_BIT]   = debug_id_pkg::SECURE_USER_HALT_NO;
    ident_word[debug_id_pkg::PCSAMPLE_BIT] = debug_id_pkg::PC_SAMPLE_PRESENT;
    ident_word[debug_id_pkg::SECEXT_BIT]   = debug_id_pkg::SECURITY_EXT_PRESENT;
    ident_word[debug_id_pkg::RSVD_MSB:debug_id_pkg::RSVD_LSB] =
      debug_id_pkg::RESERVED_ID_CODE;
    ident_word[debug_id_pkg::VARIANT_MSB:debug_id_pkg::VARIANT_LSB] =
      main_id_i[debug_id_pkg::MAIN_VARIANT_MSB:debug_id_pkg::MAIN_VARIANT_LSB];
    ident_word[debug_id_pkg::REVISION_MSB:debug_id_pkg::REVISION_LSB] =
      main_id_i[debug_id_pkg::MAIN_REVISION_MSB:debug_id_pkg::MAIN_REVISION_LSB];
  end

  // Status word, reserved bits held at zero
  always_comb begin
    status_word = '0;
    status_word[debug_id_pkg::STAT_RSVD_HI_BIT] = 1'b0;
    status_word[debug_id_pkg::STAT_RECEIVE_FULL_FLAG_BIT]  = rx_full;
    status_word[debug_id_pkg::STAT_TRANSMIT_FULL_FLAG_BIT]  = tx_full;
    status_word[debug_id_pkg::STAT_RSVD_LO_BIT] = 1'b0;
    status_word[debug_id_pkg::STAT_UDIS_BIT]    = user_disable;
  end

  // Coprocessor decode
  assign cp_take      = cp_valid_i && cp_ready_o;
  assign cp_base      = (cp_opc1_i == debug_id_pkg::CP_OPC1_BASE) &&
                        (cp_crn_i == debug_id_pkg::CP_CRN_BASE) &&
                        (cp_opc2_i == debug_id_pkg::CP_OPC2_BASE);
  assign cp_is_ident  = cp_base && (cp_crm_i == debug_id_pkg::CP_CRM_IDENT);
  assign cp_is_status = cp_base && (cp_crm_i == debug_id_pkg::CP_CRM_STATUS);
  assign cp_is_trans  = cp_base && (cp_crm_i == debug_id_pkg::CP_CRM_TRANS);
  assign cp_refused   = cp_user_i && user_disable;
  assign cp_undef     = cp_refused || !(cp_is_ident || cp_is_status || cp_is_trans);

  always_comb begin
    cp_rdata = '0;
    if (!cp_undef && !cp_write_i) begin
      if (cp_is_ident) begin
        cp_rdata = ident_word;
      end else if (cp_is_status) begin
        cp_rdata = status_word;
      end else begin
        cp_rdata = rx_data;
      end
    end
  end

  // Channel strobes
  assign rx_fill  = ext_valid_i && ext_write_i && (ext_num_i == debug_id_pkg::EXT_NUM_RX);
  assign rx_drain = cp_take && !cp_undef && cp_is_trans && !cp_write_i;
  assign tx_fill  = cp_take && !cp_undef && cp_is_trans && cp_write_i;
  assign tx_drain = ext_valid_i && !ext_write_i && (ext_num_i == debug_id_pkg::EXT_NUM_TX);

  transfer_slot #(
    .WIDTH (DATA_WIDTH)
  ) u_rx_slot (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .fill_i      (rx_fill),
    .fill_data_i (ext_wdata_i),
    .drain_i     (rx_drain),
    .data_o      (rx_data),
    .full_o      (rx_full)
  );

  transfer_slot #(
    .WIDTH (DATA_WIDTH)
  ) u_tx_slot (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .fill_i      (tx_fill),
    .fill_data_i (cp_wdata_i),
    .drain_i     (tx_drain),
    .data_o      (tx_data),
    .full_o      (tx_full)
  );

  assign rx_full_o = rx_full;
  assign tx_full_o = tx_full;

  // User access disable bit, written by the debugger
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      user_disable <= debug_id_pkg::UDIS_RESET;
    end else if (ext_valid_i && ext_write_i && (ext_num_i == debug_id_pkg::EXT_NUM_STATUS)) begin
      user_disable <= ext_wdata_i[debug_id_pkg::STAT_UDIS_BIT];
    end
  end

  // Processor answers pass a two-entry buffer
  resp_buffer #(
    .WIDTH (DATA_WIDTH + 1),
    .DEPTH (debug_id_pkg::RESP_DEPTH)
  ) u_resp (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (cp_valid_i),
    .in_ready_o  (cp_ready_o),
    .in_data_i   ({cp_undef, cp_rdata}),
    .out_valid_o (cp_rsp_valid_o),
    .out_ready_i (cp_rsp_ready_i),
    .out_data_o  ({cp_rsp_undef_o, cp_rsp_rdata_o})
  );

  // Debugger read answers, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_rvalid_o <= 1'b0;
      ext_rdata_o  <= debug_id_pkg::WORD_RESET;
    end else begin
      ext_rvalid_o <= ext_valid_i && !ext_write_i;
      if (ext_valid_i && !ext_write_i) begin
        unique case (ext_num_i)
          debug_id_pkg::EXT_NUM_IDENT:  ext_rdata_o <= ident_word;
          debug_id_pkg::EXT_NUM_RX:     ext_rdata_o <= rx_data;
          debug_id_pkg::EXT_NUM_STATUS: ext_rdata_o <= status_word;
          debug_id_pkg::EXT_NUM_TX:     ext_rdata_o <= tx_data;
          default:                      ext_rdata_o <= debug_id_pkg::WORD_RESET;
        endcase
      end
    end
  end

endmodule

// ==== design/resp_buffer.sv ====
/*
  Small FIFO with valid and ready on both sides.
  Assumes one clock; output data comes straight from storage flops.
*/
`timescale 1ns/100ps
module resp_buffer #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count < (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ==== design/transfer_slot.sv ====
/*
  One transfer register with its full flag: set on fill, clear on drain.
  Assumes fill and drain strobes are one-cycle pulses on ref_clk_i.
*/
`timescale 1ns/100ps
module transfer_slot #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             fill_i,
  input  wire logic [WIDTH-1:0] fill_data_i,
  input  wire logic             drain_i,
  output logic      [WIDTH-1:0] data_o,
  output logic                  full_o
);

  // Fill wins over a drain in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      full_o <= debug_id_pkg::FULL_RESET;
    end else if (fill_i) begin
      full_o <= 1'b1;
    end else if (drain_i) begin
      full_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= '0;
    end else if (fill_i) begin
      data_o <= fill_data_i;
    end
  end

endmodule

// ==== dv/debug_id_status_props.sv ====
/*
  Checker for the debug identification and status block.
  Assumes it is bound to debug_id_status and sees only its ports.
*/
`timescale 1ns/100ps
module debug_id_status_props #(
  parameter logic [3:0]  ARCH_VERSION = 4'h5,
  parameter int unsigned DATA_WIDTH   = 32
) (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_b_i,
  input wire logic [31:0]           main_id_i,
  input wire logic                  cp_valid_i,
  input wire logic                  cp_ready_o,
  input wire logic                  cp_write_i,
  input wire logic                  cp_user_i,
  input wire logic [2:0]            cp_opc1_i,
  input wire logic [3:0]            cp_crn_i,
  input wire logic [3:0]            cp_crm_i,
  input wire logic [2:0]            cp_opc2_i,
  input wire logic                  cp_rsp_valid_o,
  input wire logic [DATA_WIDTH-1:0] cp_rsp_rdata_o,
  input wire logic                  cp_rsp_undef_o,
  input wire logic                  ext_valid_i,
  input wire logic                  ext_write_i,
  input wire logic [9:0]            ext_num_i,
  input wire logic                  ext_rvalid_o,
  input wire logic [DATA_WIDTH-1:0] ext_rdata_o,
  input wire logic                  rx_full_o,
  input wire logic                  tx_full_o
);
  logic take, base, xfer, ext_rd;
  assign take   = cp_valid_i && cp_ready_o;
  assign base   = cp_opc1_i == 3'h0 && cp_crn_i == 4'h0 && cp_opc2_i == 3'h0;
  assign xfer   = take && base && !cp_user_i && cp_crm_i == 4'h5;
  assign ext_rd = ext_valid_i && !ext_write_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_id_hi;
    ext_rd && ext_num_i == 10'h000 |=> ext_rdata_o[31:16] == {8'h12, 4'h0, ARCH_VERSION};
  endproperty
  property p_id_mid; ext_rd && ext_num_i == 10'h000 |=> ext_rdata_o[15:8] == 8'hf0; endproperty
  property p_id_lo;
    ext_rd && ext_num_i == 10'h000
      |=> ext_rdata_o[7:0] == {$past(main_id_i[23:20]), $past(main_id_i[3:0])};
  endproperty
  property p_status;
    ext_rd && ext_num_i == 10'h022 |=> !ext_rdata_o[31] && !ext_rdata_o[28]
      && ext_rdata_o[30:29] == {$past(rx_full_o), $past(tx_full_o)};
  endproperty
  property p_rx_set; ext_valid_i && ext_write_i && ext_num_i == 10'h020 |=> rx_full_o; endproperty
  property p_rx_clr;
    xfer && !cp_write_i && !(ext_valid_i && ext_write_i) |=> !rx_full_o;
  endproperty
  property p_tx_set; xfer && cp_write_i |=> tx_full_o; endproperty
  property p_tx_clr; ext_rd && ext_num_i == 10'h023 && !xfer |=> !tx_full_o; endproperty
  property p_rvalid; 1'b1 |=> ext_rvalid_o == $past(ext_rd); endproperty
  property p_answer; take && !cp_rsp_valid_o |=> cp_rsp_valid_o; endproperty
  property p_undef;
    take && !base && !cp_rsp_valid_o |=> cp_rsp_undef_o && cp_rsp_rdata_o == '0;
  endproperty
  property p_reset; $rose(rst_b_i) |-> !rx_full_o && !tx_full_o; endproperty
  a_id_hi: assert property (p_id_hi) else $error("bad id");
  a_id_mid: assert property (p_id_mid) else $error("bad id");
  a_id_lo: assert property (p_id_lo) else $error("bad id");
  a_status: assert property (p_status) else $error("status word wrong");
  a_rx_set: assert property (p_rx_set) else $error("rx full not set");
  a_rx_clr: assert property (p_rx_clr) else $error("rx full not cleared");
  a_tx_set: assert property (p_tx_set) else $error("tx full not set");
  a_tx_clr: assert property (p_tx_clr) else $error("tx full not cleared");
  a_rvalid: assert property (p_rvalid) else $error("read pulse wrong");
  a_answer: assert property (p_answer) else $error("no answer");
  a_undef: assert property (p_undef) else $error("bad encoding answered");
  a_reset: assert property (p_reset) else $error("flags not reset");
  c_ident: cover property (ext_rd && ext_num_i == 10'h000);
  c_tx_clr: cover property (ext_rd && ext_num_i == 10'h023 && tx_full_o);
  c_stall: cover property (cp_valid_i && !cp_ready_o);
endmodule
bind debug_id_status debug_id_status_props #(
  .ARCH_VERSION(ARCH_VERSION),
  .DATA_WIDTH  (DATA_WIDTH)
) u_props (.*);

// ==== dv/debugger_model.sv ====
/*
  Debugger model on the numbered register port.
  Assumes read data is registered on the taking edge and sampled just after it.
*/
`timescale 1ns/100ps
module debugger_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  output logic             valid_o,
  output logic             write_o,
  output logic [9:0]       num_o,
  output logic [31:0]      wdata_o
);
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    num_o   = 10'h3ff;
    wdata_o = 32'h0;
  end
  task automatic access(input logic wr, input logic [9:0] num, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    @(posedge ref_clk_i);
    #1;
    valid_o = 1'b1;
    write_o = wr;
    num_o   = num;
    wdata_o = wd;
    @(posedge ref_clk_i);
    #1;
    rd      = rdata_i;
    ok      = rvalid_i;
    valid_o = 1'b0;
    write_o = ~wr;
    num_o   = ~num;
    wdata_o = ~wd;
  endtask
endmodule

// ==== dv/tb.sv ====
/*
  Self-checking bench for debug_id_status with a debugger model.
  Assumes one 100 MHz clock shared by bench, model and block.
*/
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] ARCH = 4'h5;
  logic        ref_clk_i, rst_b_i, cp_valid_i, cp_write_i, cp_user_i, cp_rsp_ready_i;
  logic        ext_valid_i, ext_write_i, cp_ready_o, cp_rsp_valid_o, cp_rsp_undef_o;
  logic        ext_rvalid_o, rx_full_o, tx_full_o, k, u;
  logic [2:0]  cp_opc1_i, cp_opc2_i;
  logic [3:0]  cp_crn_i, cp_crm_i;
  logic [9:0]  ext_num_i;
  logic [31:0] main_id_i, cp_wdata_i, cp_rsp_rdata_o, ext_wdata_i, ext_rdata_o, d, r;
  int          errors, checks, seed;
  debug_id_status #(.ARCH_VERSION(ARCH)) dut (.*);
  debugger_model dbg (.ref_clk_i(ref_clk_i), .rvalid_i(ext_rvalid_o), .rdata_i(ext_rdata_o),
    .valid_o(ext_valid_i), .write_o(ext_write_i), .num_o(ext_num_i), .wdata_o(ext_wdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] ident(input logic [31:0] m);
    return {8'h12, 4'h0, ARCH, 8'hf0, m[23:20], m[3:0]};
  endfunction
  function automatic logic [31:0] stat(input logic rx, input logic tx, input logic ud);
    return {1'b0, rx, tx, 1'b0, 15'h0, ud, 12'h0};
  endfunction
  task automatic summarize;
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wait_clk;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic cp_issue(input logic w, input logic us, input logic [2:0] o1,
                          input logic [3:0] m, input logic [31:0] wd);
    int n;
    wait_clk();
    cp_valid_i = 1'b1;
    cp_write_i = w;
    cp_user_i  = us;
    cp_opc1_i  = o1;
    cp_crm_i   = m;
    cp_wdata_i = wd;
    for (n = 0; n < 20 && cp_ready_o !== 1'b1; n++) wait_clk();
    if (n == 20) begin
      errors++;
      summarize();
    end
    wait_clk();
    cp_valid_i = 1'b0;
    cp_wdata_i = ~wd;
  endtask
  task automatic cp_take(output logic [31:0] rd, output logic un);
    int n;
    for (n = 0; n < 20 && cp_rsp_valid_o !== 1'b1; n++) wait_clk();
    if (n == 20) begin
      errors++;
      summarize();
    end
    rd = cp_rsp_rdata_o;
    un = cp_rsp_undef_o;
    wait_clk();
  endtask
  task automatic cp(input logic w, input logic us, input logic [2:0] o1, input logic [3:0] m,
                    input logic [31:0] wd, output logic [31:0] rd, output logic un);
    cp_issue(w, us, o1, m, wd);
    cp_take(rd, un);
  endtask
  initial begin
    seed = 32'ha78e81f6;
    {errors, checks} = 0;
    {rst_b_i, cp_valid_i, cp_write_i, cp_user_i, cp_opc1_i, cp_opc2_i, cp_crn_i} = 0;
    {cp_crm_i, main_id_i, cp_wdata_i} = 0;
    cp_rsp_ready_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    cmp_bit(rx_full_o, 1'b0);
    cmp_bit(tx_full_o, 1'b0);
    dbg.access(1'b0, 10'h022, 32'h0, r, k);
    cmp_bit(k, 1'b1);
    cmp_word(r, stat(1'b0, 1'b0, 1'b0));
    dbg.access(1'b0, 10'h024, 32'h0, r, k);
    cmp_word(r, 32'h0);
    for (int i = 0; i < 6; i++) begin
      main_id_i = $random(seed);
      d = $random(seed);
      dbg.access(1'b1, 10'h000, d, r, k);
      dbg.access(1'b0, 10'h000, 32'h0, r, k);
      cmp_word(r, ident(main_id_i));
      cp(1'b1, 1'b0, 3'h0, 4'h0, d, r, u);
      cp(1'b0, 1'b0, 3'h0, 4'h0, 32'h0, r, u);
      cmp_word(r, ident(main_id_i));
      cmp_bit(u, 1'b0);
      dbg.access(1'b1, 10'h020, d, r, k);
      cmp_bit(rx_full_o, 1'b1);
      cp(1'b0, 1'b0, 3'h0, 4'h1, 32'h0, r, u);
      cmp_word(r, stat(1'b1, 1'b0, 1'b0));
      if (rx_full_o === 1'b1) cp(1'b0, 1'b0, 3'h0, 4'h5, 32'h0, r, u);
      cmp_word(r, d);
      cmp_bit(rx_full_o, 1'b0);
      if (tx_full_o === 1'b0) cp(1'b1, 1'b0, 3'h0, 4'h5, ~d, r, u);
      cmp_bit(tx_full_o, 1'b1);
      dbg.access(1'b0, 10'h022, 32'h0, r, k);
      cmp_word(r, stat(1'b0, 1'b1, 1'b0));
      dbg.access(1'b0, 10'h023, 32'h0, r, k);
      cmp_word(r, ~d);
      cmp_bit(k, 1'b1);
      cmp_bit(tx_full_o, 1'b0);
    end
    dbg.access(1'b1, 10'h022, 32'h0000_1000, r, k);
    cp(1'b0, 1'b1, 3'h0, 4'h0, 32'h0, r, u);
    cmp_bit(u, 1'b1);
    cmp_word(r, 32'h0);
    cp(1'b0, 1'b0, 3'h0, 4'h1, 32'h0, r, u);
    cmp_word(r, stat(1'b0, 1'b0, 1'b1));
    cp(1'b0, 1'b0, 3'h1, 4'h0, 32'h0, r, u);
    cmp_bit(u, 1'b1);
    dbg.access(1'b1, 10'h022, 32'h0, r, k);
    cp(1'b0, 1'b1, 3'h0, 4'h0, 32'h0, r, u);
    cmp_word(r, ident(main_id_i));
    cp_rsp_ready_i = 1'b0;
    cp_issue(1'b0, 1'b0, 3'h0, 4'h0, 32'h0);
    cp_issue(1'b0, 1'b0, 3'h0, 4'h1, 32'h0);
    wait_clk();
    cp_valid_i = 1'b1;
    repeat (3) begin
      wait_clk();
      cmp_bit(cp_ready_o, 1'b0);
    end
    cp_valid_i = 1'b0;
    cp_rsp_ready_i = 1'b1;
    cp_take(r, u);
    cmp_word(r, ident(main_id_i));
    cp_take(r, u);
    cmp_word(r, stat(1'b0, 1'b0, 1'b0));
    dbg.access(1'b1, 10'h020, d, r, k);
    rst_b_i = 1'b0;
    wait_clk();
    rst_b_i = 1'b1;
    cmp_bit(rx_full_o, 1'b0);
    dbg.access(1'b0, 10'h022, 32'h0, r, k);
    cmp_word(r, stat(1'b0, 1'b0, 1'b0));
    summarize();
  end
endmodule
